// file: include/bru_defines.svh
/*
 Constants for the byte rotate unit: data width, reset values and
 operation encodings. Assumes inclusion by bare name from include/.
*/
`ifndef BRU_DEFINES_SVH
`define BRU_DEFINES_SVH
`define BRU_DATA_W      8
`define BRU_MSB         7
`define BRU_LSB         0
`define BRU_ACC_RST     8'h00
`define BRU_CARRY_RST   1'b0
`define BRU_BYTE_RST    8'h00
`define BRU_OP_W        3
`define BRU_OP_NONE     3'h0
`define BRU_OP_ROL_ACC       3'h1
`define BRU_OP_ROL_CARRY     3'h2
`define BRU_OP_ROL_CARRY_ACC 3'h3
`define BRU_OP_ROR_MEM       3'h4
`define BRU_OP_ROR_ACC       3'h5
`define BRU_OP_ROR_CARRY     3'h6
`endif

// file: include/bru_pkg.sv
/*
 Types for the byte rotate unit: operation codes, request and result
 carriers and the module state. Assumes bru_defines.svh is reachable.
*/
`default_nettype none
`include "bru_defines.svh"
package bru_pkg;
   typedef logic [`BRU_DATA_W-1:0] bru_byte_t;

   // Operation selected by the decoder; NONE means idle
   typedef logic [`BRU_OP_W-1:0] bru_op_t;

   typedef struct packed {
      logic      valid;
      bru_op_t   op;
      bru_byte_t mem_byte;
   } bru_req_t;

   typedef struct packed {
      logic      mem_we;
      bru_byte_t mem_byte;
      logic      acc_we;
      logic      carry_we;
   } bru_res_t;

   typedef struct packed {
      bru_byte_t acc;
      logic      carry;
      bru_res_t  res;
   } bru_state_t;
endpackage : bru_pkg
`default_nettype wire

// file: rtl/bru_byte_rotate_unit.sv
/*
 Byte rotate unit: executes the six single-bit rotate operations of the
 core on one data-memory byte and holds the accumulator and carry flag.
 The unit owns the accumulator and the carry flag; the memory byte is
 owned by the data memory, which hands it in with each request and
 takes the rotated value back while the write strobe is high.
 Assumes the decoder presents at most one request per cycle, level
 sampled on each rising edge of sys_clk_i, and that the memory side
 stores mem_wdata_o in the cycle that mem_we_o is high.
 Results appear at the edge that takes the request; a back-to-back
 request that uses the carry sees the flag left by the request before
 it, so the decoder needs no stall between carry operations.
 No other instruction of the core passes through this unit.
*/
`default_nettype none
`include "bru_defines.svh"
module bru_byte_rotate_unit
   import bru_pkg::*;
(
   input  wire logic      sys_clk_i,
   input  wire logic      srst_i,
   input  wire bru_req_t  req_i,
   output logic           mem_we_o,
   output bru_byte_t      mem_wdata_o,
   output bru_byte_t      acc_o,
   output logic           carry_o,
   output logic           acc_upd_o,
   output logic           carry_upd_o
);

   // Rotate by one; fill is the bit entering the vacated end
   function automatic bru_byte_t bru_rot_left(input bru_byte_t b,
                                              input logic fill);
      bru_rot_left = {b[`BRU_MSB-1:`BRU_LSB], fill};
   endfunction : bru_rot_left

   function automatic bru_byte_t bru_rot_right(input bru_byte_t b,
                                               input logic fill);
      bru_rot_right = {fill, b[`BRU_MSB:`BRU_LSB+1]};
   endfunction : bru_rot_right

   // Op classes at a glance (target, carry use, direction):
   //   ROL_ACC        accumulator  carry kept   left, old bit 7 refills
   //   ROL_CARRY      memory       carry in/out left, carry refills
   //   ROL_CARRY_ACC  accumulator  carry in/out left, carry refills
   //   ROR_MEM        memory       carry kept   right, old bit 0 refills
   //   ROR_ACC        accumulator  carry kept   right, old bit 0 refills
   //   ROR_CARRY      memory       carry in/out right, carry refills
   // Codes 0 and 7 fall out of every class, which is what makes them
   // refused without a separate legality check. The accumulator targets
   // never raise the memory strobe, so the memory byte stays as it was.

   // Ops that shift the byte towards bit 7
   function automatic logic bru_is_left(input bru_op_t op);
      case (op)
         `BRU_OP_ROL_ACC,
         `BRU_OP_ROL_CARRY,
         `BRU_OP_ROL_CARRY_ACC: bru_is_left = 1'b1;
         default:               bru_is_left = 1'b0;
      endcase
   endfunction : bru_is_left

   // Ops whose result goes back to the memory byte in place
   function automatic logic bru_is_mem(input bru_op_t op);
      case (op)
         `BRU_OP_ROL_CARRY,
         `BRU_OP_ROR_MEM,
         `BRU_OP_ROR_CARRY: bru_is_mem = 1'b1;
         default:           bru_is_mem = 1'b0;
      endcase
   endfunction : bru_is_mem

   // Ops whose result is loaded into the accumulator
   function automatic logic bru_is_acc(input bru_op_t op);
      case (op)
         `BRU_OP_ROL_ACC,
         `BRU_OP_ROL_CARRY_ACC,
         `BRU_OP_ROR_ACC: bru_is_acc = 1'b1;
         default:         bru_is_acc = 1'b0;
      endcase
   endfunction : bru_is_acc

   // Ops in which the carry flag takes part; all others must keep it
   function automatic logic bru_is_carry(input bru_op_t op);
      case (op)
         `BRU_OP_ROL_CARRY,
         `BRU_OP_ROL_CARRY_ACC,
         `BRU_OP_ROR_CARRY: bru_is_carry = 1'b1;
         default:           bru_is_carry = 1'b0;
      endcase
   endfunction : bru_is_carry

   // Bit that enters the vacated end; the carry ops use the flag as it
   // stands now, which is the value left by the previous request
   function automatic logic bru_fill(input bru_op_t   op,
                                     input bru_byte_t b,
                                     input logic      c);
      case (op)
         `BRU_OP_ROL_ACC:       bru_fill = b[`BRU_MSB];
         `BRU_OP_ROL_CARRY:     bru_fill = c;
         `BRU_OP_ROL_CARRY_ACC: bru_fill = c;
         `BRU_OP_ROR_MEM:       bru_fill = b[`BRU_LSB];
         `BRU_OP_ROR_ACC:       bru_fill = b[`BRU_LSB];
         `BRU_OP_ROR_CARRY:     bru_fill = c;
         default:               bru_fill = 1'b0;
      endcase
   endfunction : bru_fill

   // Bit pushed out of the far end; only the carry ops keep it
   function automatic logic bru_out(input logic left, input bru_byte_t b);
      if (left) begin
         bru_out = b[`BRU_MSB];
      end else begin
         bru_out = b[`BRU_LSB];
      end
   endfunction : bru_out

   // Direction select in front of the two rotators
   function automatic bru_byte_t bru_rot_byte(input logic      left,
                                              input bru_byte_t b,
                                              input logic      fill);
      if (left) begin
         bru_rot_byte = bru_rot_left(b, fill);
      end else begin
         bru_rot_byte = bru_rot_right(b, fill);
      end
   endfunction : bru_rot_byte

   // Registered state and its next value
   bru_state_t st_r;
   bru_state_t st_nxt;

   // Decoded request; kept out of the state struct because none of it
   // has to survive a clock edge
   logic      op_left;   // Shift towards bit 7
   logic      op_to_mem; // Result written back in place
   logic      op_to_acc; // Result loaded into the accumulator
   logic      op_carry;  // Carry flag takes part
   logic      req_go;    // Valid request with a known code
   logic      fill_bit;  // Bit entering the vacated end
   logic      out_bit;   // Bit leaving the far end
   bru_byte_t rot_byte;  // Rotated request byte

   // Op decode from the request
   assign op_left   = bru_is_left(req_i.op);
   assign op_to_mem = bru_is_mem(req_i.op);
   assign op_to_acc = bru_is_acc(req_i.op);
   assign op_carry  = bru_is_carry(req_i.op);
   assign req_go    = req_i.valid && (op_to_mem || op_to_acc);

   // One rotator pair serves all six ops; the op only picks the direction and
   // the fill bit. Sharing it costs a mux level but keeps the six ops
   // from drifting apart in their bit order.
   assign fill_bit = bru_fill(req_i.op, req_i.mem_byte, st_r.carry);
   assign out_bit  = bru_out(op_left, req_i.mem_byte);
   assign rot_byte = bru_rot_byte(op_left, req_i.mem_byte, fill_bit);

   // Next state. Strobes default low so each request raises them for one cycle;
   // the held values only move when their strobe is raised, so a
   // refused request leaves everything as it was.
   always_comb begin
      st_nxt              = st_r;
      st_nxt.res.mem_we   = 1'b0;
      st_nxt.res.acc_we   = 1'b0;
      st_nxt.res.carry_we = 1'b0;
      if (req_go) begin
         // In-place ops write the memory byte back
         if (op_to_mem) begin
            st_nxt.res.mem_byte = rot_byte;
            st_nxt.res.mem_we   = 1'b1;
         end
         // Accumulator ops leave the memory strobe low
         if (op_to_acc) begin
            st_nxt.acc        = rot_byte;
            st_nxt.res.acc_we = 1'b1;
         end
         // Only the carry ops touch the flag
         if (op_carry) begin
            st_nxt.carry        = out_bit;
            st_nxt.res.carry_we = 1'b1;
         end
      end
   end

   // State register; reset clears accumulator, carry and strobes
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st_r.acc          <= `BRU_ACC_RST;
         st_r.carry        <= `BRU_CARRY_RST;
         st_r.res.mem_we   <= 1'b0;
         st_r.res.mem_byte <= `BRU_BYTE_RST;
         st_r.res.acc_we   <= 1'b0;
         st_r.res.carry_we <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // All outputs come straight from the state register
   assign mem_we_o    = st_r.res.mem_we;
   assign mem_wdata_o = st_r.res.mem_byte;
   assign acc_o       = st_r.acc;
   assign carry_o     = st_r.carry;
   assign acc_upd_o   = st_r.res.acc_we;
   assign carry_upd_o = st_r.res.carry_we;

endmodule : bru_byte_rotate_unit
`default_nettype wire

// file: verif/bru_monitor.sv
/* Port checker for the rotate unit.
   Assumes it is bound to the unit and sees only its ports. */
`default_nettype none
module bru_monitor
   import bru_pkg::*;
(
   input wire logic      sys_clk_i,
   input wire logic      srst_i,
   input wire bru_req_t  req_i,
   input wire logic      mem_we_o,
   input wire bru_byte_t mem_wdata_o,
   input wire bru_byte_t acc_o,
   input wire logic      carry_o,
   input wire logic      acc_upd_o,
   input wire logic      carry_upd_o
);
   logic      v_r, t_r, c_r;
   bru_op_t   o_r;
   bru_byte_t b_r;
   // Keep each request, so a result is judged against its own cause
   always_ff @(posedge sys_clk_i) begin
      v_r <= !srst_i;
      t_r <= !srst_i && req_i.valid;
      o_r <= req_i.op;
      b_r <= req_i.mem_byte;
      c_r <= carry_o;
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   rol_acc_a: assert property (t_r && o_r == 3'h1 |-> acc_upd_o &&
      acc_o == {b_r[6:0], b_r[7]}) else $error("left to acc wrong");
   rol_carry_a: assert property (t_r && o_r == 3'h2 |-> mem_we_o && carry_o
      == b_r[7] && mem_wdata_o == {b_r[6:0], c_r}) else $error("lc");
   rol_carry_acc_a: assert property (t_r && o_r == 3'h3 |-> acc_upd_o &&
      carry_o == b_r[7] && acc_o == {b_r[6:0], c_r})
      else $error("lca");
   ror_mem_a: assert property (t_r && o_r == 3'h4 |-> mem_we_o &&
      mem_wdata_o == {b_r[0], b_r[7:1]}) else $error("right rot bad");
   ror_acc_a: assert property (t_r && o_r == 3'h5 |-> acc_upd_o &&
      acc_o == {b_r[0], b_r[7:1]}) else $error("right to acc bad");
   ror_carry_a: assert property (t_r && o_r == 3'h6 |-> mem_we_o && carry_o
      == b_r[0] && mem_wdata_o == {c_r, b_r[7:1]}) else $error("rc");
   carry_kept_a: assert property (v_r && !(t_r && o_r inside {3'h2, 3'h3,
      3'h6}) |-> carry_o == c_r && !carry_upd_o) else $error("carry");
   mem_kept_a: assert property (v_r && !(t_r && o_r inside {3'h2, 3'h4,
      3'h6}) |-> !mem_we_o) else $error("memory written");
   cover property (mem_we_o && carry_upd_o);
   cover property (acc_upd_o && carry_upd_o);
   cover property (mem_we_o ##1 mem_we_o);
endmodule : bru_monitor
bind bru_byte_rotate_unit bru_monitor u_mon (.sys_clk_i(sys_clk_i),
   .srst_i(srst_i), .req_i(req_i), .mem_we_o(mem_we_o), .acc_o(acc_o),
   .mem_wdata_o(mem_wdata_o), .carry_o(carry_o), .acc_upd_o(acc_upd_o),
   .carry_upd_o(carry_upd_o));
`default_nettype wire

// file: verif/tb_byte_rotate_unit.sv
/* Bench for the rotate unit.
   Assumes a 100 ns clock; inputs move 2 ns after each rising edge. */
`default_nettype none
`include "bru_defines.svh"
module tb_byte_rotate_unit
   import bru_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic      sys_clk_i = 1'b0, srst_i = 1'b1, mem_we_o, carry_o;
   logic      acc_upd_o, carry_upd_o;
   bru_req_t  req_i = '0;
   bru_byte_t mem_wdata_o, acc_o;
   int        mismatches = 0, comparisons = 0, cycles = 0;
   localparam int CYCLE_LIMIT = 1000; // Whole run needs about 30 cycles
   bru_byte_rotate_unit dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .req_i(req_i), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
      .acc_o(acc_o), .carry_o(carry_o), .acc_upd_o(acc_upd_o),
      .carry_upd_o(carry_upd_o));

   // Free-running clock, 100 ns period
   initial begin
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   // Ceiling on run length; a hang counts as a mismatch
   always @(posedge sys_clk_i) begin
      cycles = cycles + 1;
      if (cycles == CYCLE_LIMIT) begin
         mismatches++;
         tally_and_finish();
      end
   end

   // Compares use !== so an unknown output never slips through
   task automatic check_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_bit

   task automatic check_byte(input bru_byte_t got, input bru_byte_t exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_byte

   // All six outputs, looked at while the results of the last edge stand
   task automatic expect_out(input logic we, input bru_byte_t wd,
                             input bru_byte_t acc, input logic c,
                             input logic aup, input logic cup);
      check_bit(mem_we_o, we);
      check_byte(mem_wdata_o, wd);
      check_byte(acc_o, acc);
      check_bit(carry_o, c);
      check_bit(acc_upd_o, aup);
      check_bit(carry_upd_o, cup);
   endtask : expect_out

   // One request, taken at the next edge; returns with it still driven
   // so that a following call replaces it with no idle cycle between
   task automatic run_op(input bru_op_t op, input bru_byte_t b);
      req_i = '{1'b1, op, b};
      @(posedge sys_clk_i);
      #2;
   endtask : run_op

   task automatic idle();
      req_i = '0;
      @(posedge sys_clk_i);
      #2;
   endtask : idle

   task automatic test_rol_acc();
      run_op(`BRU_OP_ROL_ACC, 8'h81);
      expect_out(1'b0, 8'h00, 8'h03, 1'b0, 1'b1, 1'b0);
      run_op(`BRU_OP_ROL_ACC, 8'h5a);
      expect_out(1'b0, 8'h00, 8'hb4, 1'b0, 1'b1, 1'b0);
      idle();
      expect_out(1'b0, 8'h00, 8'hb4, 1'b0, 1'b0, 1'b0);
   endtask : test_rol_acc

   task automatic test_rol_carry();
      run_op(`BRU_OP_ROL_CARRY, 8'h81);
      expect_out(1'b1, 8'h02, 8'hb4, 1'b1, 1'b0, 1'b1);
      run_op(`BRU_OP_ROL_CARRY, 8'h40);
      expect_out(1'b1, 8'h81, 8'hb4, 1'b0, 1'b0, 1'b1);
      idle();
      expect_out(1'b0, 8'h81, 8'hb4, 1'b0, 1'b0, 1'b0);
   endtask : test_rol_carry

   task automatic test_rol_carry_acc();
      run_op(`BRU_OP_ROL_CARRY_ACC, 8'hc3);
      expect_out(1'b0, 8'h81, 8'h86, 1'b1, 1'b1, 1'b1);
      run_op(`BRU_OP_ROL_CARRY_ACC, 8'h01);
      expect_out(1'b0, 8'h81, 8'h03, 1'b0, 1'b1, 1'b1);
      idle();
      expect_out(1'b0, 8'h81, 8'h03, 1'b0, 1'b0, 1'b0);
   endtask : test_rol_carry_acc

   task automatic test_ror_mem();
      run_op(`BRU_OP_ROR_MEM, 8'h01);
      expect_out(1'b1, 8'h80, 8'h03, 1'b0, 1'b0, 1'b0);
      run_op(`BRU_OP_ROR_MEM, 8'ha6);
      expect_out(1'b1, 8'h53, 8'h03, 1'b0, 1'b0, 1'b0);
      idle();
      expect_out(1'b0, 8'h53, 8'h03, 1'b0, 1'b0, 1'b0);
   endtask : test_ror_mem

   task automatic test_ror_carry();
      run_op(`BRU_OP_ROR_CARRY, 8'h01);
      expect_out(1'b1, 8'h00, 8'h03, 1'b1, 1'b0, 1'b1);
      run_op(`BRU_OP_ROR_CARRY, 8'h11);
      expect_out(1'b1, 8'h88, 8'h03, 1'b1, 1'b0, 1'b1);
      idle();
      expect_out(1'b0, 8'h88, 8'h03, 1'b1, 1'b0, 1'b0);
   endtask : test_ror_carry

   // Runs with the carry set, so a flag change would show
   task automatic test_ror_acc();
      run_op(`BRU_OP_ROR_ACC, 8'h01);
      expect_out(1'b0, 8'h88, 8'h80, 1'b1, 1'b1, 1'b0);
      run_op(`BRU_OP_ROR_ACC, 8'h3c);
      expect_out(1'b0, 8'h88, 8'h1e, 1'b1, 1'b1, 1'b0);
      idle();
      expect_out(1'b0, 8'h88, 8'h1e, 1'b1, 1'b0, 1'b0);
   endtask : test_ror_acc

   // Valid low, idle code and unused code must change nothing
   task automatic test_refused();
      req_i = '{1'b0, `BRU_OP_ROL_ACC, 8'hff};
      @(posedge sys_clk_i);
      #2;
      expect_out(1'b0, 8'h88, 8'h1e, 1'b1, 1'b0, 1'b0);
      req_i = '{1'b1, `BRU_OP_NONE, 8'hff};
      @(posedge sys_clk_i);
      #2;
      expect_out(1'b0, 8'h88, 8'h1e, 1'b1, 1'b0, 1'b0);
      req_i = '{1'b1, 3'h7, 8'hff};
      @(posedge sys_clk_i);
      #2;
      expect_out(1'b0, 8'h88, 8'h1e, 1'b1, 1'b0, 1'b0);
   endtask : test_refused

   // Reset in mid-run, then a request at the first edge after release
   task automatic test_mid_reset();
      srst_i = 1'b1;
      req_i  = '{1'b1, `BRU_OP_ROL_CARRY, 8'hff};
      @(posedge sys_clk_i);
      #2;
      expect_out(1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      srst_i = 1'b0;
      req_i  = '{1'b1, `BRU_OP_ROL_CARRY, 8'h80};
      @(posedge sys_clk_i);
      #2;
      expect_out(1'b1, 8'h00, 8'h00, 1'b1, 1'b0, 1'b1);
      idle();
      expect_out(1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
   endtask : test_mid_reset

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // Reset for six cycles, then the scenarios in an order that leaves
   // the carry set before the flag-keeping ROR_ACC test
   initial begin
      repeat (6) @(posedge sys_clk_i);
      #2;
      srst_i = 1'b0;
      expect_out(1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
      test_rol_acc();
      test_rol_carry();
      test_rol_carry_acc();
      test_ror_mem();
      test_ror_carry();
      test_ror_acc();
      test_refused();
      test_mid_reset();
      tally_and_finish();
   end
endmodule : tb_byte_rotate_unit
`default_nettype wire
